// file: bfiu_regs.vh
`ifndef BFIU_REGS_VH
`define BFIU_REGS_VH

// ==========================================================================
// register byte offsets
`define BFIU_OFS_INSTR     12'h000
`define BFIU_OFS_FLAGS     12'h004
`define BFIU_OFS_STATE     12'h008
`define BFIU_OFS_GPR_BASE  12'h080
`define BFIU_OFS_IO_BASE   12'h100
`define BFIU_WIN_MASK      12'hF80

// ==========================================================================
// reset values
`define BFIU_RST_FLAGS     8'h00
`define BFIU_RST_REG       8'h00
`define BFIU_RST_INSTR     12'h000

// ==========================================================================
// instruction word fields
`define BFIU_OP_LSB        0
`define BFIU_OP_MSB        3
`define BFIU_IDX_LSB       4
`define BFIU_IDX_MSB       8
`define BFIU_BIT_LSB       9
`define BFIU_BIT_MSB       11

// ==========================================================================
// operation codes
`define BFIU_OP_NOP        4'h0
`define BFIU_OP_IO_SET     4'h1
`define BFIU_OP_IO_CLR     4'h2
`define BFIU_OP_SHL        4'h3
`define BFIU_OP_SHR_LOG    4'h4
`define BFIU_OP_ROL_C      4'h5
`define BFIU_OP_ROR_C      4'h6
`define BFIU_OP_SHR_ARI    4'h7
`define BFIU_OP_SWAP       4'h8
`define BFIU_OP_BIT_TO_T   4'h9
`define BFIU_OP_T_TO_BIT   4'hA
`define BFIU_OP_FLAG_SET   4'hB
`define BFIU_OP_FLAG_CLR   4'hC
`define BFIU_OP_SLEEP      4'hD
`define BFIU_OP_WDOG       4'hE
`define BFIU_OP_BREAK      4'hF

// ==========================================================================
// status flag positions
`define BFIU_FLG_C         0
`define BFIU_FLG_Z         1
`define BFIU_FLG_N         2
`define BFIU_FLG_V         3
`define BFIU_FLG_S         4
`define BFIU_FLG_H         5
`define BFIU_FLG_T         6
`define BFIU_FLG_I         7

// ==========================================================================
// execution timing in cycles
`define BFIU_CYC_IO_BIT    2
`define BFIU_CYC_SINGLE    1

`endif

// file: bfiu_shift_unit.v
`timescale 1ns/1ps
`include "bfiu_regs.vh"

module bfiu_shift_unit (
  // operation select
  input  wire [3:0] op,
  // operand and carry in
  input  wire [7:0] opnd,
  input  wire       c_in,
  // result and flags
  output reg  [7:0] res,
  output reg        c_out,
  output wire       z_out,
  output wire       n_out,
  output wire       v_out
);

  // ========================================================================
  // shift and rotate datapath
  always @* begin
    res   = opnd;
    c_out = c_in;
    case (op)
      `BFIU_OP_SHL: begin
        res   = {opnd[6:0], 1'b0};
        c_out = opnd[7];
      end
      `BFIU_OP_ROL_C: begin
        res   = {opnd[6:0], c_in};
        c_out = opnd[7];
      end
      `BFIU_OP_SHR_LOG: begin
        res   = {1'b0, opnd[7:1]};
        c_out = opnd[0];
      end
      `BFIU_OP_SHR_ARI: begin
        res   = {opnd[7], opnd[7:1]};
        c_out = opnd[0];
      end
      `BFIU_OP_ROR_C: begin
        res   = {c_in, opnd[7:1]};
        c_out = opnd[0];
      end
      `BFIU_OP_SWAP: begin
        res   = {opnd[3:0], opnd[7:4]};
        c_out = c_in;
      end
      default: begin
        res   = opnd;
        c_out = c_in;
      end
    endcase
  end

  assign z_out = (res == 8'h00);
  assign n_out = res[7];
  // overflow after a shift is sign xor carry out
  assign v_out = res[7] ^ c_out;

endmodule // bfiu_shift_unit

// file: bfiu_core.v
// Added by the designer: the register offsets and the APB register port.
`timescale 1ns/1ps
`include "bfiu_regs.vh"

// What this block does
// - io bit set: forces one, flags kept, two cycles
// - io bit clear: forces zero, flags kept, two cycles
// - left shift/rotate: one cycle, updates Z,C,N,V
// - right shifts/rotate: one cycle, updates Z,C,N,V
// - register bit copied into transfer flag, one cycle
// - transfer flag copied into register bit
// - signed flag set or clear, alone
// - overflow flag set or clear, alone
// - half-carry flag set or clear, alone
// - sleep: one cycle, flags kept, requests low power
// - watchdog restart in one cycle, flags kept
// - break only signals debug, flags kept
module bfiu_core (
  // apb clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // apb request
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  input  wire [3:0]  pstrb,
  // apb answer
  output wire        pready,
  output reg  [31:0] prdata,
  output wire        pslverr,
  // core control events
  output reg         sleep_req,
  output reg         wdog_restart,
  output reg         debug_break,
  output wire        busy
);

  // ========================================================================
  // states
  localparam [1:0] ST_IDLE = 2'b00;
  localparam [1:0] ST_EXEC = 2'b01;
  localparam [1:0] ST_IO2  = 2'b10;

  // address kinds
  localparam [2:0] AK_NONE  = 3'd0;
  localparam [2:0] AK_INSTR = 3'd1;
  localparam [2:0] AK_FLAGS = 3'd2;
  localparam [2:0] AK_STATE = 3'd3;
  localparam [2:0] AK_GPR   = 3'd4;
  localparam [2:0] AK_IO    = 3'd5;

  // ========================================================================
  // storage
  reg  [7:0]  gpr_q [0:31];
  reg  [7:0]  io_q  [0:31];
  reg  [7:0]  status_flags_register_q;
  reg  [11:0] instr_q;
  reg  [1:0]  state_q;
  reg  [7:0]  io_tmp_q;
  reg  [7:0]  exec_cnt_q;
  reg         rd_valid_q;
  integer     i;
  integer     j;

  // ========================================================================
  // address decode, shared by read and write paths
  function [2:0] addr_kind;
    input [11:0] a;
    begin
      if (a[1:0] != 2'b00)
        addr_kind = AK_NONE;
      else if (a == `BFIU_OFS_INSTR)
        addr_kind = AK_INSTR;
      else if (a == `BFIU_OFS_FLAGS)
        addr_kind = AK_FLAGS;
      else if (a == `BFIU_OFS_STATE)
        addr_kind = AK_STATE;
      else if ((a & `BFIU_WIN_MASK) == `BFIU_OFS_GPR_BASE)
        addr_kind = AK_GPR;
      else if ((a & `BFIU_WIN_MASK) == `BFIU_OFS_IO_BASE)
        addr_kind = AK_IO;
      else
        addr_kind = AK_NONE;
    end
  endfunction

  // ========================================================================
  // one bit of a byte replaced, shared by io bit ops and the transfer-flag copy into a register bit
  function [7:0] bit_put;
    input [7:0] val;
    input [2:0] pos;
    input       b;
    reg   [7:0] m;
    begin
      m       = 8'h01 << pos;
      bit_put = b ? (val | m) : (val & ~m);
    end
  endfunction

  wire [2:0] akind   = addr_kind(paddr);
  wire [4:0] win_idx = paddr[6:2];

  // ========================================================================
  // instruction fields
  wire [3:0] op   = instr_q[`BFIU_OP_MSB:`BFIU_OP_LSB];
  wire [4:0] ridx = instr_q[`BFIU_IDX_MSB:`BFIU_IDX_LSB];
  wire [2:0] bsel = instr_q[`BFIU_BIT_MSB:`BFIU_BIT_LSB];
  wire [7:0] gsel = gpr_q[ridx];

  // ========================================================================
  // apb handshake
  // ready only after a not-busy sample, so read data never predates a commit
  assign busy    = (state_q != ST_IDLE);
  assign pready  = penable & rd_valid_q;
  assign pslverr = pready & (akind == AK_NONE);

  wire acc_done = psel & penable & pready;
  wire wr_take  = acc_done & pwrite & (akind != AK_NONE);
  wire lane0    = pstrb[0];

  // ========================================================================
  // shift datapath
  wire [7:0] sh_res;
  wire       sh_c;
  wire       sh_z;
  wire       sh_n;
  wire       sh_v;

  bfiu_shift_unit u_shift (
    .op    (op),
    .opnd  (gsel),
    .c_in  (status_flags_register_q[`BFIU_FLG_C]),
    .res   (sh_res),
    .c_out (sh_c),
    .z_out (sh_z),
    .n_out (sh_n),
    .v_out (sh_v)
  );

  wire is_shift = (op == `BFIU_OP_SHL)     | (op == `BFIU_OP_ROL_C) |
                  (op == `BFIU_OP_SHR_LOG) | (op == `BFIU_OP_SHR_ARI) |
                  (op == `BFIU_OP_ROR_C);
  wire is_io    = (op == `BFIU_OP_IO_SET) | (op == `BFIU_OP_IO_CLR);
  wire in_exec  = (state_q == ST_EXEC);

  // ========================================================================
  // read data and answer timing
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata     <= 32'h0000_0000;
      rd_valid_q <= 1'b0;
    end else if (acc_done) begin
      rd_valid_q <= 1'b0;
    end else if (psel && !busy) begin
      rd_valid_q <= 1'b1;
      case (akind)
        AK_INSTR: prdata <= {20'h00000, instr_q};
        AK_FLAGS: prdata <= {24'h000000, status_flags_register_q};
        AK_STATE: prdata <= {16'h0000, exec_cnt_q, 6'h00, state_q};
        AK_GPR:   prdata <= {24'h000000, gpr_q[win_idx]};
        AK_IO:    prdata <= {24'h000000, io_q[win_idx]};
        default:  prdata <= 32'h0000_0000;
      endcase
    end else begin
      rd_valid_q <= 1'b0;
    end
  end

  // ========================================================================
  // sequencer
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q    <= ST_IDLE;
      instr_q    <= `BFIU_RST_INSTR;
      io_tmp_q   <= `BFIU_RST_REG;
      exec_cnt_q <= 8'h00;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (wr_take && akind == AK_INSTR && lane0) begin
            instr_q <= pwdata[11:0];
            state_q <= ST_EXEC;
          end
        end
        ST_EXEC: begin
          exec_cnt_q <= exec_cnt_q + 8'h01;
          if (is_io) begin
            // first cycle fetches the io byte, second writes it back
            io_tmp_q <= io_q[ridx];
            state_q  <= ST_IO2;
          end else begin
            state_q  <= ST_IDLE;
          end
        end
        ST_IO2: begin
          state_q <= ST_IDLE;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ========================================================================
  // io register file
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (i = 0; i < 32; i = i + 1)
        io_q[i] <= `BFIU_RST_REG;
    end else if (state_q == ST_IO2) begin
      io_q[ridx] <= bit_put(io_tmp_q, bsel, op == `BFIU_OP_IO_SET);
    end else if (wr_take && akind == AK_IO && lane0) begin
      io_q[win_idx] <= pwdata[7:0];
    end
  end

  // ========================================================================
  // general register file
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (j = 0; j < 32; j = j + 1)
        gpr_q[j] <= `BFIU_RST_REG;
    end else if (in_exec && (is_shift || op == `BFIU_OP_SWAP)) begin
      gpr_q[ridx] <= sh_res;
    end else if (in_exec && op == `BFIU_OP_T_TO_BIT) begin
      gpr_q[ridx] <= bit_put(gsel, bsel, status_flags_register_q[`BFIU_FLG_T]);
    end else if (wr_take && akind == AK_GPR && lane0) begin
      gpr_q[win_idx] <= pwdata[7:0];
    end
  end

  // ========================================================================
  // status flags
  // io bit ops, sleep, watchdog, break, swap and nop leave flags alone
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_flags_register_q <= `BFIU_RST_FLAGS;
    end else if (in_exec) begin
      case (op)
        `BFIU_OP_SHL, `BFIU_OP_ROL_C: begin
          status_flags_register_q[`BFIU_FLG_Z] <= sh_z;
          status_flags_register_q[`BFIU_FLG_C] <= sh_c;
          status_flags_register_q[`BFIU_FLG_N] <= sh_n;
          status_flags_register_q[`BFIU_FLG_V] <= sh_v;
        end
        `BFIU_OP_SHR_LOG, `BFIU_OP_SHR_ARI, `BFIU_OP_ROR_C: begin
          status_flags_register_q[`BFIU_FLG_Z] <= sh_z;
          status_flags_register_q[`BFIU_FLG_C] <= sh_c;
          status_flags_register_q[`BFIU_FLG_N] <= sh_n;
          status_flags_register_q[`BFIU_FLG_V] <= sh_v;
        end
        `BFIU_OP_BIT_TO_T: begin
          status_flags_register_q[`BFIU_FLG_T] <= gsel[bsel];
        end
        // bit field picks the flag; only that one position is written
        `BFIU_OP_FLAG_SET: begin
          status_flags_register_q[bsel] <= 1'b1;
        end
        `BFIU_OP_FLAG_CLR: begin
          status_flags_register_q[bsel] <= 1'b0;
        end
        default: begin
          status_flags_register_q <= status_flags_register_q;
        end
      endcase
    end else if (wr_take && akind == AK_FLAGS && lane0) begin
      status_flags_register_q <= pwdata[7:0];
    end
  end

  // ========================================================================
  // core control pulses
  // the sleep controller outside picks the low-power mode from this request
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sleep_req    <= 1'b0;
      wdog_restart <= 1'b0;
      debug_break  <= 1'b0;
    end else begin
      sleep_req    <= in_exec & (op == `BFIU_OP_SLEEP);
      wdog_restart <= in_exec & (op == `BFIU_OP_WDOG);
      debug_break  <= in_exec & (op == `BFIU_OP_BREAK);
    end
  end

endmodule // bfiu_core

// file: bfiu_core_properties.sv
`timescale 1ns/1ps
`include "bfiu_regs.vh"

// ==========
// checker on the core's ports
module bfiu_core_properties (
  // clock and reset
  input wire        pclk,
  input wire        presetn,
  // apb request
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0]  pstrb,
  // apb answer
  input wire        pready,
  input wire [31:0] prdata,
  input wire        pslverr,
  // core events
  input wire        sleep_req,
  input wire        wdog_restart,
  input wire        debug_break,
  input wire        busy
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  wire [3:0] op_w = pwdata[3:0];
  // an instruction is issued only by a completed, strobed write to the issue word
  wire issue = psel && penable && pready && pwrite && pstrb[0] && paddr == `BFIU_OFS_INSTR;
  wire io_op = op_w == `BFIU_OP_IO_SET || op_w == `BFIU_OP_IO_CLR;
  wire iss_one   = issue && !io_op;
  wire iss_sleep = issue && op_w == `BFIU_OP_SLEEP;
  wire iss_wdog  = issue && op_w == `BFIU_OP_WDOG;
  wire iss_break = issue && op_w == `BFIU_OP_BREAK;

  // registered event: quiet in the execute cycle, high in the next one only
  property p_pulse(ev, sig);
    ev |=> !sig ##1 sig ##1 !sig;
  endproperty

  a_io_two_cycle: assert property (issue && io_op |=> busy [*2] ##1 !busy)
    else $error("io bit op busy length wrong");
  a_single_cycle: assert property (iss_one |=> busy ##1 !busy)
    else $error("single cycle op busy length wrong");
  a_sleep_pulse: assert property (p_pulse(iss_sleep, sleep_req))
    else $error("sleep request pulse wrong");
  a_wdog_pulse: assert property (p_pulse(iss_wdog, wdog_restart))
    else $error("watchdog restart pulse wrong");
  a_break_pulse: assert property (p_pulse(iss_break, debug_break))
    else $error("debug break pulse wrong");
  a_sleep_cause: assert property (sleep_req |-> $past(busy))
    else $error("sleep request without execution");
  a_wdog_alone: assert property (wdog_restart |-> !sleep_req && !debug_break)
    else $error("watchdog restart with other event");
  a_bus_stall: assert property (busy |-> !pready)
    else $error("bus answered during execution");
  a_err_ready: assert property (pslverr |-> pready && psel && penable)
    else $error("error outside access cycle");
  a_err_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read returned data");

  c_io_issue: cover property (issue && io_op);
  c_sleep: cover property (sleep_req);
  c_refused: cover property (pslverr);
endmodule // bfiu_core_properties

bind bfiu_core bfiu_core_properties u_props (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .pstrb, .pready, .prdata, .pslverr, .sleep_req, .wdog_restart,
  .debug_break, .busy);

// file: tb_bfiu_core.sv
`timescale 1ns/1ps
`include "bfiu_regs.vh"
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin errors++; \
  $display("ERROR %s exp %0h got %0h", n, e, g); end end

module tb_bfiu_core;
  // ==========
  // stimulus and observation
  localparam logic [11:0] FLG_A = `BFIU_OFS_FLAGS;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, rd;
  logic [3:0]  pstrb = 4'hF;
  logic        err;
  logic [7:0]  fi, v, ex;
  logic [8:0]  sr;
  wire         pready, pslverr, sleep_req, wdog_restart, debug_break, busy;
  wire  [31:0] prdata;
  int          errors = 0, n_compared = 0, cyc = 0, pulses = 0;

  always #12.5 pclk = ~pclk;

  bfiu_core dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .pready, .prdata, .pslverr, .sleep_req, .wdog_restart, .debug_break, .busy);

  always @(posedge pclk) begin
    cyc++;
    if (sleep_req || wdog_restart || debug_break) pulses++;
    if (cyc == 5000) begin
      errors++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // ==========
  // bus access; pready and the answer are taken at the rising edge ending the access
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic run(input logic [3:0] o, input logic [4:0] i, input logic [2:0] b);
    xfer(1'b1, `BFIU_OFS_INSTR, {20'h0, b, i, o});
  endtask

  task automatic rdchk(input string n, input logic [11:0] a, input logic [7:0] e);
    xfer(1'b0, a, 32'h0);
    `CHK(n, {24'h0, e}, rd)
  endtask

  // carry out in bit 8, result below
  function automatic logic [8:0] shx(input int op, input logic [7:0] x, input logic c);
    case (op)
      3: return {x, 1'b0};
      4: return {x[0], 1'b0, x[7:1]};
      5: return {x, c};
      6: return {x[0], c, x[7:1]};
      7: return {x[0], x[7], x[7:1]};
      default: return {1'b0, x[3:0], x[7:4]};
    endcase
  endfunction

  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rdchk("flags reset", FLG_A, 8'h00);
    for (int op = 3; op <= 8; op++) for (int k = 0; k < 3; k++) begin
      v = (k == 0) ? 8'h81 : (k == 1) ? 8'h01 : 8'h40;
      fi = (k == 1) ? 8'h30 : 8'h31;
      xfer(1'b1, FLG_A, {24'h0, fi});
      xfer(1'b1, 12'h08C, {24'h0, v});
      run(op[3:0], 5'h03, 3'h0);
      sr = shx(op, v, fi[0]);
      ex = (op == 8) ? fi : {fi[7:4], sr[7] ^ sr[8], sr[7], sr[7:0] == 8'h00, sr[8]};
      rdchk("shift result", 12'h08C, sr[7:0]);
      rdchk("shift flags", FLG_A, ex);
    end
    xfer(1'b1, FLG_A, 32'h5A);
    xfer(1'b1, 12'h114, 32'hA5);
    run(`BFIU_OP_IO_SET, 5'h05, 3'h1);
    rdchk("io set", 12'h114, 8'hA7);
    run(`BFIU_OP_IO_CLR, 5'h05, 3'h7);
    rdchk("io clear", 12'h114, 8'h27);
    rdchk("io flags", FLG_A, 8'h5A);
    xfer(1'b1, FLG_A, 32'h0F);
    xfer(1'b1, 12'h09C, 32'h10);
    run(`BFIU_OP_BIT_TO_T, 5'h07, 3'h4);
    rdchk("bit to t", FLG_A, 8'h4F);
    xfer(1'b1, 12'h0A0, 32'h80);
    run(`BFIU_OP_T_TO_BIT, 5'h08, 3'h2);
    rdchk("t to bit", 12'h0A0, 8'h84);
    rdchk("t to bit flags", FLG_A, 8'h4F);
    // each flag set then cleared alone; neighbours must not move
    xfer(1'b1, FLG_A, 32'h0);
    ex = 8'h00;
    for (int f = 0; f < 16; f++) begin
      run((f < 8) ? `BFIU_OP_FLAG_SET : `BFIU_OP_FLAG_CLR, 5'h00, f[2:0]);
      ex[f[2:0]] = (f < 8);
      rdchk("flag op", FLG_A, ex);
    end
    xfer(1'b1, FLG_A, 32'hC3);
    for (int o = 13; o <= 16; o++) begin
      run(o[3:0], 5'h00, 3'h0);
      rdchk("control flags", FLG_A, 8'hC3);
    end
    `CHK("event pulses", 3, pulses)
    // 42 instructions issued so far, core idle
    xfer(1'b0, `BFIU_OFS_STATE, 32'h0);
    `CHK("exec count", 32'h0000_2A00, rd)
    xfer(1'b0, 12'h00C, 32'h0);
    `CHK("unmapped read", 33'h100000000, {err, rd})
    xfer(1'b1, 12'h005, 32'hFF);
    `CHK("misaligned write", 1'b1, err)
    pstrb <= 4'h0;
    xfer(1'b1, FLG_A, 32'hFF);
    pstrb <= 4'hF;
    rdchk("strobe off", FLG_A, 8'hC3);
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rdchk("flags second reset", FLG_A, 8'h00);
    xfer(1'b0, `BFIU_OFS_STATE, 32'h0);
    `CHK("state second reset", 32'h0, rd)
    tally_and_finish();
  end
endmodule // tb_bfiu_core
